//--- dv/mtrl_range_lookup_sva.sv
// Checker: port-level assertions of the range lookup
`default_nettype none

module mtrl_range_lookup_sva
	import mtrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [STRB_W-1:0] pstrb,
	input wire logic pready,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pslverr,
	input wire logic lookup_req,
	input wire logic [PAGE_W-1:0] lookup_page,
	input wire logic lookup_ack,
	input wire mtrl_result_s lookup_result
);
	// ----------
	// Enable shadow
	// ----------
	// Byte lane 1 only: a low-lane write must not move the flags
	logic e_q;
	logic fe_q;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			e_q <= 1'b0;
			fe_q <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == OFF_DEF && pstrb[1]) begin
			e_q <= pwdata[DEF_E_BIT];
			fe_q <= pwdata[DEF_FE_BIT];
		end
	end

	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence

	one_wait_a: assert property (s_wait |=> s_answer)
		else $error("pready not one cycle after access");
	ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("pready outside access phase");
	err_zero_a: assert property (pslverr |-> pready && prdata == '0)
		else $error("pslverr without pready or with data");
	misalign_err_a: assert property ((s_wait and (paddr[1:0] != 2'b00)) |=> pslverr)
		else $error("misaligned access not refused");
	err_pulse_a: assert property (pslverr |=> !pslverr)
		else $error("pslverr longer than one cycle");
	write_zero_a: assert property (pready && pwrite |-> prdata == '0)
		else $error("write answer carries data");
	ack_follow_a: assert property (lookup_req |=> lookup_ack)
		else $error("lookup ack missing");
	ack_cause_a: assert property (lookup_ack |-> $past(lookup_req))
		else $error("lookup ack without request");
	result_hold_a: assert property (!lookup_ack |-> $stable(lookup_result))
		else $error("lookup result moved without ack");
	typing_off_a: assert property (
		lookup_req && !e_q |=> lookup_result == mtrl_result_s'{SRC_OFF, TYPE_UC})
		else $error("typing off did not give uncacheable");
	fixed_gate_a: assert property (lookup_req && !fe_q |=> lookup_result.src != SRC_FIXED)
		else $error("fixed type used while disabled");
	fixed_span_a: assert property (
		lookup_req && lookup_page > FIX_4K_LAST |=> lookup_result.src != SRC_FIXED)
		else $error("fixed type above first megabyte");
	reset_clear_a: assert property (
		$fell(reset) |-> !pready && !lookup_ack && lookup_result == '0)
		else $error("outputs not clear after reset");

endmodule : mtrl_range_lookup_sva

bind mtrl_range_lookup mtrl_range_lookup_sva u_sva (.core_clk, .reset, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .lookup_req,
	.lookup_page, .lookup_ack, .lookup_result);

`default_nettype wire

//--- dv/mtrl_range_lookup_tb_top.sv
// Testbench: register and lookup scenarios of the range lookup
`default_nettype none

module mtrl_range_lookup_tb_top
	import mtrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic lookup_req, lookup_ack;
	logic [APB_AW-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [STRB_W-1:0] pstrb;
	logic [PAGE_W-1:0] lookup_page;
	mtrl_result_s lookup_result;
	int failures, checks;
	// Band edges of every fixed region size
	logic [PAGE_W-1:0] pg [10] = '{20'h0_0000, 20'h0_000F, 20'h0_0010, 20'h0_007F,
		20'h0_0080, 20'h0_0083, 20'h0_0084, 20'h0_00BF, 20'h0_00C0, 20'h0_00FF};

	mtrl_range_lookup u_dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .pready, .prdata, .pslverr, .lookup_req, .lookup_page, .lookup_ack,
		.lookup_result);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ----------
	// Tasks
	// ----------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	task automatic tend(input string n);
		$display("test %s done", n);
	endtask : tend

	// Request held until pready is sampled high, then released
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, e});
	endtask : rdc

	task automatic lk(input logic [PAGE_W-1:0] p, input mtrl_src_e sr, input logic [7:0] t);
		@(posedge core_clk);
		lookup_req <= 1'b1;
		lookup_page <= p;
		@(posedge core_clk);
		lookup_req <= 1'b0;
		@(negedge core_clk);
		chk({31'h0, lookup_ack}, 32'h0000_0001);
		chk({22'h0, lookup_result}, {22'h0, sr, t});
	endtask : lk

	// Byte index of the fixed region holding a page
	function automatic logic [7:0] fx(input logic [PAGE_W-1:0] p);
		if (p < 20'h0_0080) return 8'(p >> 4);
		if (p < 20'h0_00C0) return 8'h08 + 8'((p - 20'h0_0080) >> 2);
		return 8'h18 + 8'(p - 20'h0_00C0);
	endfunction : fx

	// ----------
	// Sequence
	// ----------
	initial begin
		failures = 0;
		checks = 0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		lookup_req = 1'b0;
		lookup_page = '0;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		rdc(OFF_DEF, 32'h0000_0000, 1'b0);
		rdc(OFF_VAR + 12'h004, 32'h0000_0000, 1'b0);
		rdc(OFF_CAP, 32'h0000_0108, 1'b0);
		lk(20'h0_0100, SRC_OFF, TYPE_UC);
		tend("reset");
		// Each fixed byte holds its own index, so a wrong band shows up
		for (int k = 0; k < FIX_WORDS; k++) begin
			wr(OFF_FIX + 12'(4 * k), {8'(4 * k + 3), 8'(4 * k + 2), 8'(4 * k + 1), 8'(4 * k)});
		end
		wr(OFF_DEF, 32'h0000_0C06);
		foreach (pg[i]) begin
			lk(pg[i], SRC_FIXED, fx(pg[i]));
		end
		lk(20'h0_0100, SRC_DEFAULT, TYPE_WB);
		tend("fixed");
		wr(OFF_DEF, 32'h0000_0806);
		lk(20'h0_0010, SRC_DEFAULT, TYPE_WB);
		apb(1'b1, OFF_DEF, 32'h0000_0001, 4'h1);
		lk(20'h0_0010, SRC_DEFAULT, TYPE_WC);
		rdc(OFF_DEF, 32'h0000_0801, 1'b0);
		tend("gating");
		wr(OFF_DEF, 32'h0000_0001);
		wr(OFF_VAR, 32'h0010_0006);
		wr(OFF_VAR + 12'h004, 32'hFFF0_0800);
		wr(OFF_VAR + 12'h008, 32'h0014_0000);
		wr(OFF_VAR + 12'h00C, 32'hFFFF_0800);
		wr(OFF_VAR + 12'h010, 32'h0030_0001);
		wr(OFF_VAR + 12'h014, 32'hFFF0_0000);
		wr(OFF_VAR + 12'h038, 32'h0040_0004);
		wr(OFF_VAR + 12'h03C, 32'hFFF0_0800);
		lk(20'h0_0150, SRC_OFF, TYPE_UC);
		wr(OFF_DEF, 32'h0000_0801);
		lk(20'h0_0150, SRC_VAR, TYPE_WB);
		lk(20'h0_0200, SRC_DEFAULT, TYPE_WC);
		lk(20'h0_0145, SRC_VAR, TYPE_UC);
		lk(20'h0_0300, SRC_DEFAULT, TYPE_WC);
		lk(20'h0_0400, SRC_VAR, TYPE_WT);
		wr(OFF_VAR + 12'h00C, 32'hFFFF_0000);
		lk(20'h0_0145, SRC_VAR, TYPE_WB);
		rdc(OFF_STAT, 32'h0000_0306, 1'b0);
		// Query walk: a partial last page still counts as a page
		wr(OFF_QBASE, 32'h0015_0000);
		wr(OFF_QSIZE, 32'h0000_1001);
		rdc(OFF_QSTAT, 32'h0000_0602, 1'b0);
		wr(OFF_QBASE, 32'h001F_F000);
		wr(OFF_QSIZE, 32'h0000_2000);
		rdc(OFF_QSTAT, 32'h0000_060A, 1'b0);
		wr(OFF_QBASE, 32'hFFFF_F000);
		wr(OFF_QSIZE, 32'h0000_2000);
		rdc(OFF_QSTAT, 32'h0000_0006, 1'b0);
		wr(OFF_QSIZE, 32'h0000_0000);
		rdc(OFF_QSTAT, 32'h0000_0006, 1'b0);
		wr(OFF_DEF, 32'h0000_0001);
		lk(20'h0_0150, SRC_OFF, TYPE_UC);
		tend("variable and query");
		rdc(12'h0FC, 32'h0000_0000, 1'b1);
		rdc(12'h006, 32'h0000_0000, 1'b1);
		wr(OFF_CAP, 32'h0000_0000);
		rdc(OFF_CAP, 32'h0000_0108, 1'b0);
		tend("refusals");
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rdc(OFF_VAR + 12'h004, 32'h0000_0000, 1'b0);
		rdc(OFF_DEF, 32'h0000_0000, 1'b0);
		lk(20'h0_0150, SRC_OFF, TYPE_UC);
		tend("second reset");
		test_done();
	end

endmodule : mtrl_range_lookup_tb_top

`default_nettype wire

//--- rtl/mtrl_fixed_lookup.sv
// Fixed band decode: page number to fixed type byte
`default_nettype none

module mtrl_fixed_lookup
	import mtrl_pkg::*;
(
	input wire logic [FIX_BYTES*TYPE_W-1:0] fix_table,
	input wire logic [PAGE_W-1:0] page,
	output logic hit,
	output logic [TYPE_W-1:0] mtype
);

	// ----------------------------------------------------------------
	// Band decode
	// ----------------------------------------------------------------
	function automatic logic [FIX_IDX_W-1:0] fix_index(input logic [PAGE_W-1:0] pg);
		logic [FIX_IDX_W-1:0] idx;
		idx = '0;
		if (pg <= FIX_64K_LAST) begin
			idx = {4'h0, pg[6:4]};
		end else if (pg <= FIX_16K_LAST) begin
			idx = FIX_16K_BASE + {3'h0, pg[5:2]};
		end else begin
			idx = FIX_4K_BASE + {1'b0, pg[5:0]};
		end
		return idx;
	endfunction : fix_index

	assign hit = (page <= FIX_4K_LAST);
	assign mtype = fix_table[fix_index(page)*TYPE_W +: TYPE_W];

endmodule : mtrl_fixed_lookup

`default_nettype wire

//--- rtl/mtrl_pkg.sv
// Package: constants, register map and carrier types of the memory type range lookup
`default_nettype none

package mtrl_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned PAGE_W = 20;
	localparam int unsigned TYPE_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = 4;
	localparam int unsigned APB_AW = 12;
	localparam int unsigned VAR_PAIRS = 8;
	localparam int unsigned FIX_BYTES = 88;
	localparam int unsigned FIX_WORDS = 22;
	localparam int unsigned FIX_IDX_W = 7;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned PAGE_LSB = 12;
	localparam int unsigned CAP_FIX_BIT = 8;
	localparam int unsigned DEF_FE_BIT = 10;
	localparam int unsigned DEF_E_BIT = 11;
	localparam int unsigned MASK_V_BIT = 11;
	localparam int unsigned STAT_SRC_LSB = 8;
	localparam int unsigned Q_BUSY_BIT = 0;
	localparam int unsigned Q_DONE_BIT = 1;
	localparam int unsigned Q_INVALID_BIT = 2;
	localparam int unsigned Q_MIXED_BIT = 3;
	localparam int unsigned Q_TYPE_LSB = 8;

	// ----------------------------------------------------------------
	// Memory type encodings
	// ----------------------------------------------------------------
	localparam logic [TYPE_W-1:0] TYPE_UC = 8'h00;
	localparam logic [TYPE_W-1:0] TYPE_WC = 8'h01;
	localparam logic [TYPE_W-1:0] TYPE_WT = 8'h04;
	localparam logic [TYPE_W-1:0] TYPE_WP = 8'h05;
	localparam logic [TYPE_W-1:0] TYPE_WB = 8'h06;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [APB_AW-1:0] OFF_CAP = 12'h000;
	localparam logic [APB_AW-1:0] OFF_DEF = 12'h004;
	localparam logic [APB_AW-1:0] OFF_STAT = 12'h008;
	localparam logic [APB_AW-1:0] OFF_QBASE = 12'h010;
	localparam logic [APB_AW-1:0] OFF_QSIZE = 12'h014;
	localparam logic [APB_AW-1:0] OFF_QSTAT = 12'h018;
	localparam logic [APB_AW-1:0] OFF_FIX = 12'h100;
	localparam logic [APB_AW-1:0] OFF_FIX_END = OFF_FIX + APB_AW'(FIX_WORDS * 4);
	localparam logic [APB_AW-1:0] OFF_VAR = 12'h200;
	localparam logic [APB_AW-1:0] OFF_VAR_END = OFF_VAR + APB_AW'(VAR_PAIRS * 8);

	// ----------------------------------------------------------------
	// Fixed region bounds, as last page number of each band and first table index of the 16K and 4K bands
	// ----------------------------------------------------------------
	localparam logic [PAGE_W-1:0] FIX_64K_LAST = 20'h0_007F;
	localparam logic [PAGE_W-1:0] FIX_16K_LAST = 20'h0_00BF;
	localparam logic [PAGE_W-1:0] FIX_4K_LAST = 20'h0_00FF;
	localparam logic [FIX_IDX_W-1:0] FIX_16K_BASE = 7'h08;
	localparam logic [FIX_IDX_W-1:0] FIX_4K_BASE = 7'h18;

	// ----------------------------------------------------------------
	// Capability contents
	// ----------------------------------------------------------------
	localparam logic CAP_FIX_SUPPORTED = 1'b1;
	localparam logic [TYPE_W-1:0] CAP_VARIABLE_PAIR_COUNT = TYPE_W'(VAR_PAIRS);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_OFF = 2'b00,
		SRC_FIXED = 2'b01,
		SRC_VAR = 2'b11,
		SRC_DEFAULT = 2'b10
	} mtrl_src_e;

	typedef enum logic [1:0] {
		Q_IDLE = 2'b00,
		Q_WALK = 2'b01,
		Q_DONE = 2'b11
	} mtrl_qstate_e;

	typedef struct packed {
		logic valid;
		logic [PAGE_W-1:0] mask;
		logic [PAGE_W-1:0] base;
		logic [TYPE_W-1:0] mtype;
	} mtrl_pair_s;

	typedef struct packed {
		mtrl_src_e src;
		logic [TYPE_W-1:0] mtype;
	} mtrl_result_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
		logic [TYPE_W-1:0] def_type;
		logic fix_en;
		logic range_en;
		logic [FIX_BYTES*TYPE_W-1:0] fix;
		mtrl_pair_s [VAR_PAIRS-1:0] pairs;
		logic ack;
		mtrl_result_s res;
		mtrl_qstate_e qstate;
		logic [PAGE_W-1:0] qbase;
		logic [DATA_W-1:0] qsize;
		logic [PAGE_W-1:0] qpage;
		logic [PAGE_W-1:0] qlast;
		logic qinvalid;
		logic qmixed;
		logic qfirst;
		logic [TYPE_W-1:0] qtype;
	} mtrl_state_s;

endpackage : mtrl_pkg

`default_nettype wire

//--- rtl/mtrl_range_lookup.sv
// Top: APB register file, page type resolver and range query engine
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none

module mtrl_range_lookup
	import mtrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [STRB_W-1:0] pstrb,
	output logic pready,
	output logic [DATA_W-1:0] prdata,
	output logic pslverr,
	input wire logic lookup_req,
	input wire logic [PAGE_W-1:0] lookup_page,
	output logic lookup_ack,
	output mtrl_result_s lookup_result
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	mtrl_state_s s_q;
	mtrl_state_s s_d;

	logic [PAGE_W-1:0] res_page;
	logic fix_hit;
	logic [TYPE_W-1:0] fix_type;
	logic var_hit;
	logic [TYPE_W-1:0] var_type;
	mtrl_result_s res;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic in_fix(input logic [APB_AW-1:0] a);
		return (a >= OFF_FIX) && (a < OFF_FIX_END);
	endfunction : in_fix

	function automatic logic in_var(input logic [APB_AW-1:0] a);
		return (a >= OFF_VAR) && (a < OFF_VAR_END);
	endfunction : in_var

	function automatic logic reg_mapped(input logic [APB_AW-1:0] a);
		logic ok;
		ok = (a == OFF_CAP) || (a == OFF_DEF) || (a == OFF_STAT);
		ok = ok || (a == OFF_QBASE) || (a == OFF_QSIZE) || (a == OFF_QSTAT);
		ok = ok || in_fix(a) || in_var(a);
		return ok && (a[1:0] == 2'b00);
	endfunction : reg_mapped

	function automatic logic [4:0] fix_word(input logic [APB_AW-1:0] a);
		logic [APB_AW-1:0] rel;
		rel = a - OFF_FIX;
		return rel[6:2];
	endfunction : fix_word

	function automatic logic [2:0] pair_sel(input logic [APB_AW-1:0] a);
		logic [APB_AW-1:0] rel;
		rel = a - OFF_VAR;
		return rel[5:3];
	endfunction : pair_sel

	function automatic logic [DATA_W-1:0] merge_strb(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wd,
		input logic [STRB_W-1:0] strb
	);
		logic [DATA_W-1:0] r;
		r = old;
		for (int b = 0; b < int'(STRB_W); b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge_strb

	function automatic logic [DATA_W-1:0] base_word(input mtrl_pair_s p);
		logic [DATA_W-1:0] w;
		w = '0;
		w[PAGE_LSB +: PAGE_W] = p.base;
		w[TYPE_W-1:0] = p.mtype;
		return w;
	endfunction : base_word

	function automatic logic [DATA_W-1:0] mask_word(input mtrl_pair_s p);
		logic [DATA_W-1:0] w;
		w = '0;
		w[PAGE_LSB +: PAGE_W] = p.mask;
		w[MASK_V_BIT] = p.valid;
		return w;
	endfunction : mask_word

	function automatic logic [DATA_W-1:0] read_word(
		input mtrl_state_s s,
		input logic [APB_AW-1:0] a
	);
		logic [DATA_W-1:0] w;
		w = '0;
		if (a == OFF_CAP) begin
			w[TYPE_W-1:0] = CAP_VARIABLE_PAIR_COUNT;
			w[CAP_FIX_BIT] = CAP_FIX_SUPPORTED;
		end else if (a == OFF_DEF) begin
			w[TYPE_W-1:0] = s.def_type;
			w[DEF_FE_BIT] = s.fix_en;
			w[DEF_E_BIT] = s.range_en;
		end else if (a == OFF_STAT) begin
			w[TYPE_W-1:0] = s.res.mtype;
			w[STAT_SRC_LSB +: 2] = s.res.src;
		end else if (a == OFF_QBASE) begin
			w[PAGE_LSB +: PAGE_W] = s.qbase;
		end else if (a == OFF_QSIZE) begin
			w = s.qsize;
		end else if (a == OFF_QSTAT) begin
			w[Q_BUSY_BIT] = (s.qstate == Q_WALK);
			w[Q_DONE_BIT] = (s.qstate == Q_DONE);
			w[Q_INVALID_BIT] = s.qinvalid;
			w[Q_MIXED_BIT] = s.qmixed;
			w[Q_TYPE_LSB +: TYPE_W] = s.qtype;
		end else if (in_fix(a)) begin
			w = s.fix[fix_word(a)*DATA_W +: DATA_W];
		end else if (in_var(a)) begin
			if (a[2]) begin
				w = mask_word(s.pairs[pair_sel(a)]);
			end else begin
				w = base_word(s.pairs[pair_sel(a)]);
			end
		end
		return w;
	endfunction : read_word

	// Size zero, or an end past the top of the 4 GB space, is refused
	function automatic logic query_invalid(
		input logic [DATA_W-1:0] sz,
		input logic [PAGE_W+PAGE_LSB:0] end_a
	);
		logic wraps;
		wraps = end_a[PAGE_W+PAGE_LSB] && (end_a[PAGE_W+PAGE_LSB-1:0] != '0);
		return (sz == '0) || wraps;
	endfunction : query_invalid

	// ----------------------------------------------------------------
	// Resolver, shared by lookups and the query walk
	// ----------------------------------------------------------------
	// Lookups win the shared resolver; a walk only stalls, never corrupts.
	assign res_page = lookup_req ? lookup_page : s_q.qpage;

	mtrl_fixed_lookup u_fixed (
		.fix_table(s_q.fix),
		.page(res_page),
		.hit(fix_hit),
		.mtype(fix_type)
	);

	mtrl_var_lookup u_var (
		.pairs(s_q.pairs),
		.page(res_page),
		.hit(var_hit),
		.mtype(var_type)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic access;
		logic answer;
		logic do_write;
		logic [DATA_W-1:0] wr_word;
		logic [PAGE_W+PAGE_LSB:0] end_addr;
		logic [PAGE_W+PAGE_LSB:0] last_addr;
		mtrl_pair_s p;
		access = 1'b0;
		answer = 1'b0;
		do_write = 1'b0;
		wr_word = '0;
		end_addr = '0;
		last_addr = '0;
		p = '0;
		s_d = s_q;

		// ----------------------------------------------------------------
		// Page type, reads state of this very cycle
		// ----------------------------------------------------------------
		res.src = SRC_DEFAULT;
		res.mtype = s_q.def_type;
		if (!s_q.range_en) begin
			res.src = SRC_OFF;
			res.mtype = TYPE_UC;
		end else if (CAP_FIX_SUPPORTED && s_q.fix_en && fix_hit) begin
			res.src = SRC_FIXED;
			res.mtype = fix_type;
		end else if (var_hit) begin
			res.src = SRC_VAR;
			res.mtype = var_type;
		end

		// ----------------------------------------------------------------
		// Lookup port
		// ----------------------------------------------------------------
		s_d.ack = lookup_req;
		if (lookup_req) begin
			s_d.res = res;
		end

		// ----------------------------------------------------------------
		// APB answer, one cycle into the access phase
		// ----------------------------------------------------------------
		access = psel && penable;
		answer = access && !s_q.pready;
		s_d.pready = answer;
		// Error stands with pready only, never into the next cycle
		s_d.pslverr = answer && !reg_mapped(paddr);
		if (answer) begin
			// Refused and write answers carry zero, so no stale word leaks
			s_d.prdata = '0;
			if (!pwrite && reg_mapped(paddr)) begin
				s_d.prdata = read_word(s_q, paddr);
			end
		end
		do_write = access && s_q.pready && pwrite && reg_mapped(paddr);
		wr_word = merge_strb(read_word(s_q, paddr), pwdata, pstrb);

		// ----------------------------------------------------------------
		// Query walk, one page per free cycle
		// ----------------------------------------------------------------
		unique case (s_q.qstate)
			Q_IDLE: begin
			end
			Q_WALK: begin
				if (!lookup_req) begin
					if (s_q.qfirst) begin
						s_d.qtype = res.mtype;
						s_d.qfirst = 1'b0;
					end else if (res.mtype != s_q.qtype) begin
						// Stop at the first difference; later pages cannot undo it
						s_d.qmixed = 1'b1;
						s_d.qstate = Q_DONE;
					end
					if (s_q.qpage == s_q.qlast) begin
						s_d.qstate = Q_DONE;
					end else begin
						s_d.qpage = s_q.qpage + 1'b1;
					end
				end
			end
			Q_DONE: begin
			end
			default: begin
				s_d.qstate = Q_IDLE;
			end
		endcase

		// ----------------------------------------------------------------
		// Register writes; only local writes ever change the ranges
		// ----------------------------------------------------------------
		if (do_write) begin
			// Read-only words fall through every arm and are dropped
			if (paddr == OFF_DEF) begin
				s_d.def_type = wr_word[TYPE_W-1:0];
				s_d.fix_en = wr_word[DEF_FE_BIT];
				s_d.range_en = wr_word[DEF_E_BIT];
			end else if (paddr == OFF_QBASE) begin
				s_d.qbase = wr_word[PAGE_LSB +: PAGE_W];
			end else if (paddr == OFF_QSIZE && s_q.qstate != Q_WALK) begin
				// Size write starts a query; ignored while one is running
				end_addr = {1'b0, s_q.qbase, {PAGE_LSB{1'b0}}} + {1'b0, wr_word};
				last_addr = end_addr - 1'b1;
				s_d.qsize = wr_word;
				s_d.qpage = s_q.qbase;
				s_d.qlast = last_addr[PAGE_LSB +: PAGE_W];
				s_d.qmixed = 1'b0;
				s_d.qfirst = 1'b1;
				s_d.qtype = TYPE_UC;
				s_d.qinvalid = query_invalid(wr_word, end_addr);
				s_d.qstate = s_d.qinvalid ? Q_DONE : Q_WALK;
			end else if (in_fix(paddr)) begin
				s_d.fix[fix_word(paddr)*DATA_W +: DATA_W] = wr_word;
			end else if (in_var(paddr)) begin
				p = s_q.pairs[pair_sel(paddr)];
				if (paddr[2]) begin
					p.mask = wr_word[PAGE_LSB +: PAGE_W];
					p.valid = wr_word[MASK_V_BIT];
				end else begin
					p.base = wr_word[PAGE_LSB +: PAGE_W];
					p.mtype = wr_word[TYPE_W-1:0];
				end
				s_d.pairs[pair_sel(paddr)] = p;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Whole state clears, a superset of the valid bits and global enable.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, straight from flip-flops
	// ----------------------------------------------------------------
	assign pready = s_q.pready;
	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr;
	assign lookup_ack = s_q.ack;
	assign lookup_result = s_q.res;

endmodule : mtrl_range_lookup

`default_nettype wire

//--- rtl/mtrl_var_lookup.sv
// Variable pair match and overlap resolution
`default_nettype none

module mtrl_var_lookup
	import mtrl_pkg::*;
(
	input wire mtrl_pair_s [VAR_PAIRS-1:0] pairs,
	input wire logic [PAGE_W-1:0] page,
	output logic hit,
	output logic [TYPE_W-1:0] mtype
);

	logic [VAR_PAIRS-1:0] match;
	logic [VAR_PAIRS-1:0] is_uc;

	// ----------------------------------------------------------------
	// Per pair compare
	// ----------------------------------------------------------------
	for (genvar g = 0; g < VAR_PAIRS; g++) begin : g_pair
		assign match[g] = pairs[g].valid &&
			((page & pairs[g].mask) == (pairs[g].base & pairs[g].mask));
		assign is_uc[g] = (pairs[g].mtype == TYPE_UC);
	end

	// ----------------------------------------------------------------
	// Overlap: uncacheable beats all, else lowest matching pair
	// ----------------------------------------------------------------
	always_comb begin
		hit = |match;
		mtype = TYPE_UC;
		for (int i = int'(VAR_PAIRS) - 1; i >= 0; i--) begin
			if (match[i]) begin
				mtype = pairs[i].mtype;
			end
		end
		if (|(match & is_uc)) begin
			mtype = TYPE_UC;
		end
	end

endmodule : mtrl_var_lookup

`default_nettype wire
